// >>> hw/acqtc_pkg.sv
package acqtc_pkg;

  // Register byte offsets
  localparam logic [7:0] ACQTC_ADR_CTRL = 8'h00;
  localparam logic [7:0] ACQTC_ADR_SRC = 8'h04;
  localparam logic [7:0] ACQTC_ADR_OUT = 8'h08;
  localparam logic [7:0] ACQTC_ADR_CMD = 8'h0c;
  localparam logic [7:0] ACQTC_ADR_CONVS = 8'h10;
  localparam logic [7:0] ACQTC_ADR_PRE = 8'h14;
  localparam logic [7:0] ACQTC_ADR_POST = 8'h18;
  localparam logic [7:0] ACQTC_ADR_SCAN_IV = 8'h1c;
  localparam logic [7:0] ACQTC_ADR_CONV_IV = 8'h20;
  localparam logic [7:0] ACQTC_ADR_STATUS = 8'h24;

  // Control register fields
  localparam int CTRL_PRETRIG = 0;
  localparam int CTRL_SCAN_EXT = 1;
  localparam int CTRL_CONV_EXT = 2;
  localparam int CTRL_TB_EXT = 3;
  localparam int CTRL_TB_SLOW = 4;
  localparam int CTRL_SCAN_LEVEL = 5;
  localparam int CTRL_HOLD_EN = 6;
  localparam int CTRL_HOLD_POL = 7;
  localparam int CTRL_START_PIN = 8;
  localparam int CTRL_SW_GATE = 9;
  localparam logic [31:0] CTRL_MASK = 32'h000003ff;

  // Source select fields: 3 bits per signal, polarity bits from POL_BASE
  localparam int SIG_START = 0;
  localparam int SIG_REF = 1;
  localparam int SIG_SCAN = 2;
  localparam int SIG_CONV = 3;
  localparam int SIG_PAUSE = 4;
  localparam int SIG_TB = 5;
  localparam int NUM_SIG = 6;
  localparam int SRC_FIELD_W = 3;
  localparam int POL_BASE = 24;
  localparam logic [31:0] SRC_MASK = 32'h3f03ffff;

  // Output routing fields: enable at base, line code in the next 3 bits
  localparam int OUT_START = 0;
  localparam int OUT_REF = 4;
  localparam int OUT_SCAN = 8;
  localparam int OUT_CONV = 12;
  localparam logic [31:0] OUT_MASK = 32'h0000ffff;

  // Command bits
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;

  // Count register masks and reset values
  localparam logic [31:0] CONVS_MASK = 32'h0000ffff;
  localparam logic [31:0] COUNT_MASK = 32'h00ffffff;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] SRC_RST = 32'h00000000;
  localparam logic [31:0] OUT_RST = 32'h00000000;
  localparam logic [31:0] CONVS_RST = 32'h00000001;
  localparam logic [31:0] PRE_RST = 32'h00000000;
  localparam logic [31:0] POST_RST = 32'h00000001;
  localparam logic [31:0] SCAN_IV_RST = 32'h00000014;
  localparam logic [31:0] CONV_IV_RST = 32'h00000010;

  // Timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CLK_MHZ = 125;
  localparam int PULSE_MIN_NS = 50;
  localparam int HOLD_DELAY_NS = 50;
  localparam int HOLD_WIDTH_NS = 400;
  localparam int TB_FAST_MHZ = 20;
  localparam int TB_SLOW_KHZ = 100;
  localparam int PULSE_CYC = (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_DELAY_CYC = (HOLD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_WIDTH_CYC = (HOLD_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TB_SLOW_DIV = CLK_MHZ * 1000 / TB_SLOW_KHZ;

  typedef enum logic [1:0] {ACQTC_IDLE, ACQTC_PRE, ACQTC_ARM, ACQTC_POST} acqtc_state_t;

endpackage : acqtc_pkg

// >>> hw/acqtc_top.sv
`timescale 1ns/1ps

// What this block does
// R1: Software picks each timing signal's source line
// R2: Per-input polarity; detection fixed per signal
// R3: Start in/out on front, bus; star input only
// R4: Start edge begins post and pretriggered sequences
// R5: Start output pulses high on every sequence start
// R6: Pretrigger start from software unless pin selected
// R7: Reference edge starts posttrigger phase, pretrigger only
// R8: Quantity counter ignores reference until pretrigger done
// R9: Reference output pulses high at posttrigger point
// R10: Scan edge begins scan, starts convert gap counter
// R11: Scan output: short pulse or scan-in-progress level
// R12: Converts masked until scan start; first conversion rules
// R13: Internal sweep counter runs from start until stop
// R14: Scans, conversions only in sequence; pause gates
// R15: Convert clock edge starts one conversion
// R16: Convert output pulses low per conversion, bus only
// R17: Gap counter reloads per conversion and per scan
// R18: Pause gate level with polarity, never an output
// R19: Pause changes act only at scan boundaries
// R20: Sweep counter on 20 MHz, 100 kHz or external
// R21: External timebase at most 20 MHz, 23 ns phases
// R22: Sample-held pulse 400 ns wide, 50 ns delayed
// R23: Inputs synchronised before edge or level detection
// R24: Counts and reloads are software-programmed registers
module acqtc_top
  import acqtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trig_front_in,
  input wire logic [5:0] trig_bus_in,
  input wire logic trig_star_in,
  output logic trig_front_out,
  output logic trig_front_oe_n,
  output logic [5:0] trig_bus_out,
  output logic [5:0] trig_bus_oe_n,
  output logic adc_convert,
  output logic sample_held_pulse,
  output logic acq_running
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  function automatic logic pick_line(input logic [7:0] lines, input logic [2:0] code);
    return lines[code];
  endfunction : pick_line

  function automatic logic [6:0] line_map(input logic en, input logic [2:0] code);
    logic [6:0] res;
    res = 7'h00;
    if (en && code <= 3'h6) begin
      res[code] = 1'b1;
    end
    return res;
  endfunction : line_map

  function automatic logic [3:0] pulse_next(input logic [3:0] cnt, input logic evt);
    logic [3:0] res;
    res = cnt;
    if (evt) begin
      res = 4'(PULSE_CYC);
    end else if (cnt != 4'h0) begin
      res = cnt - 4'h1;
    end
    return res;
  endfunction : pulse_next

  // Configuration registers
  logic [31:0] ctrl;
  logic [31:0] src;
  logic [31:0] outsel;
  logic [31:0] convs;
  logic [31:0] pre_cnt;
  logic [31:0] post_cnt;
  logic [31:0] scan_iv;
  logic [31:0] conv_iv;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire [7:0] bus_adr = {wb_adr_i[7:2], 2'b00};
  wire wr_ctrl = bus_wr & (bus_adr == ACQTC_ADR_CTRL);
  wire wr_src = bus_wr & (bus_adr == ACQTC_ADR_SRC);
  wire wr_out = bus_wr & (bus_adr == ACQTC_ADR_OUT);
  wire wr_cmd = bus_wr & (bus_adr == ACQTC_ADR_CMD) & wb_sel_i[0];
  wire wr_convs = bus_wr & (bus_adr == ACQTC_ADR_CONVS);
  wire wr_pre = bus_wr & (bus_adr == ACQTC_ADR_PRE);
  wire wr_post = bus_wr & (bus_adr == ACQTC_ADR_POST);
  wire wr_scan_iv = bus_wr & (bus_adr == ACQTC_ADR_SCAN_IV);
  wire wr_conv_iv = bus_wr & (bus_adr == ACQTC_ADR_CONV_IV);
  wire sw_start = wr_cmd & wb_dat_i[CMD_START];
  wire sw_stop = wr_cmd & wb_dat_i[CMD_STOP];

  // Input synchroniser, line code 0 front, 1..6 bus, 7 star
  logic [7:0] sync_a;
  logic [7:0] sync_b;
  logic [NUM_SIG-1:0] sig_lvl;
  logic [NUM_SIG-1:0] sig_prev;
  wire [NUM_SIG-1:0] sig_edge = sig_lvl & ~sig_prev;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
      sig_prev <= 6'h00;
    end else begin
      sync_a <= {trig_star_in, trig_bus_in, trig_front_in}; // R23
      sync_b <= sync_a; // R23
      sig_prev <= sig_lvl;
    end
  end

  always_comb begin
    sig_lvl = 6'h00;
    for (int i = 0; i < NUM_SIG; i++) begin
      sig_lvl[i] = pick_line(sync_b, src[i*SRC_FIELD_W +: SRC_FIELD_W]) ^ src[POL_BASE + i]; // R1 R2
    end
  end

  // Sequencer state
  acqtc_state_t state;
  acqtc_state_t next_state;
  logic [23:0] cq;
  logic [23:0] next_cq;
  logic scanning;
  logic [15:0] conv_left;
  logic [15:0] gap;
  logic [23:0] sweep;
  logic scan_done;
  wire running = (state != ACQTC_IDLE);
  wire start_evt = ctrl[CTRL_START_PIN] ? sig_edge[SIG_START] : sw_start; // R4 R6
  wire seq_begin = (state == ACQTC_IDLE) & start_evt;
  wire ref_hit = (state == ACQTC_ARM) & sig_edge[SIG_REF]; // R7 R8
  wire seq_end = (state == ACQTC_POST) & (cq == 24'h0);

  always_comb begin
    next_state = state;
    next_cq = cq;
    case (state)
      ACQTC_IDLE: begin
        if (start_evt) begin
          if (ctrl[CTRL_PRETRIG]) begin
            next_state = ACQTC_PRE; // R4
            next_cq = pre_cnt[23:0]; // R8
          end else begin
            next_state = ACQTC_POST; // R4 R7
            next_cq = post_cnt[23:0];
          end
        end
      end
      ACQTC_PRE: begin
        if (cq == 24'h0) begin
          next_state = ACQTC_ARM; // R8
          next_cq = post_cnt[23:0]; // R8
        end else if (scan_done) begin
          next_cq = cq - 24'h1; // R8
        end
      end
      ACQTC_ARM: begin
        if (ref_hit) begin
          next_state = ACQTC_POST; // R7
        end
      end
      ACQTC_POST: begin
        if (cq == 24'h0) begin
          next_state = ACQTC_IDLE; // R8 R13
        end else if (scan_done) begin
          next_cq = cq - 24'h1;
        end
      end
      default: begin
        next_state = ACQTC_IDLE;
      end
    endcase
    if (sw_stop) begin
      next_state = ACQTC_IDLE; // R13
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ACQTC_IDLE;
      cq <= 24'h0;
    end else begin
      state <= next_state;
      cq <= next_cq;
    end
  end

  // Scan timebase
  logic [7:0] tb_acc;
  logic [10:0] tb_slow;
  wire [7:0] tb_sum = tb_acc + 8'(TB_FAST_MHZ);
  wire tb_fast_tick = (tb_sum >= 8'(CLK_MHZ));
  wire tb_slow_tick = (tb_slow == 11'(TB_SLOW_DIV - 1));
  wire tb_ext_tick = sig_edge[SIG_TB]; // R20 R21
  wire tb_tick = ctrl[CTRL_TB_EXT] ? tb_ext_tick :
                 (ctrl[CTRL_TB_SLOW] ? tb_slow_tick : tb_fast_tick); // R20

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tb_acc <= 8'h00;
      tb_slow <= 11'h000;
    end else begin
      tb_acc <= tb_fast_tick ? (tb_sum - 8'(CLK_MHZ)) : tb_sum; // R20
      tb_slow <= tb_slow_tick ? 11'h000 : (tb_slow + 11'h001); // R20
    end
  end

  // Sweep period counter and scan start
  wire int_scan_req = running & tb_tick & (sweep <= 24'h1); // R13 R20
  wire scan_req = ctrl[CTRL_SCAN_EXT] ? sig_edge[SIG_SCAN] : int_scan_req; // R10 R13
  wire gate = sig_lvl[SIG_PAUSE] | ctrl[CTRL_SW_GATE]; // R14 R18
  wire scan_begin = scan_req & running & ~scanning & ~gate & ~seq_end; // R14 R18 R19

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sweep <= 24'h0;
    end else if (seq_begin || !running) begin
      sweep <= scan_iv[23:0]; // R13 R24
    end else if (tb_tick) begin
      sweep <= (sweep <= 24'h1) ? scan_iv[23:0] : (sweep - 24'h1); // R13 R20
    end
  end

  // Conversions within a scan
  wire conv_int = ~ctrl[CTRL_CONV_EXT] & (gap == 16'h0); // R12 R17
  wire conv_ext = ctrl[CTRL_CONV_EXT] & sig_edge[SIG_CONV]; // R12 R15
  wire conv_fire = running & scanning & (conv_int | conv_ext); // R12 R14
  wire conv_last = (conv_left <= 16'h1);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scanning <= 1'b0;
      conv_left <= 16'h0;
      gap <= 16'h0;
      scan_done <= 1'b0;
    end else begin
      scan_done <= conv_fire & conv_last;
      if (!running) begin
        scanning <= 1'b0; // R14
        gap <= conv_iv[15:0];
      end else if (scan_begin) begin
        scanning <= 1'b1; // R10
        conv_left <= convs[15:0]; // R24
        gap <= conv_iv[15:0]; // R10 R17
      end else if (conv_fire) begin
        conv_left <= conv_left - 16'h1;
        gap <= conv_iv[15:0]; // R17
        scanning <= ~conv_last; // R11 R19
      end else if (scanning && gap != 16'h0) begin
        gap <= gap - 16'h1; // R17
      end else if (!scanning) begin
        gap <= conv_iv[15:0]; // R17
      end
    end
  end

  // Output pulse shaping
  logic [3:0] p_start;
  logic [3:0] p_ref;
  logic [3:0] p_scan;
  logic [3:0] p_conv;
  logic [5:0] hold_cnt;
  wire start_on = (p_start != 4'h0);
  wire ref_on = (p_ref != 4'h0);
  wire scan_on = ctrl[CTRL_SCAN_LEVEL] ? scanning : (p_scan != 4'h0); // R11
  wire conv_on = (p_conv != 4'h0);
  wire hold_on = (hold_cnt != 6'h0) && (hold_cnt <= 6'(HOLD_WIDTH_CYC)); // R22
  wire next_hold = ctrl[CTRL_HOLD_EN] ? (hold_on ^ ctrl[CTRL_HOLD_POL]) :
                   ctrl[CTRL_HOLD_POL]; // R22

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      p_start <= 4'h0;
      p_ref <= 4'h0;
      p_scan <= 4'h0;
      p_conv <= 4'h0;
      hold_cnt <= 6'h0;
    end else begin
      p_start <= pulse_next(p_start, seq_begin); // R5
      p_ref <= pulse_next(p_ref, ref_hit); // R9
      p_scan <= pulse_next(p_scan, scan_begin); // R11
      p_conv <= pulse_next(p_conv, conv_fire); // R16
      if (conv_fire) begin
        hold_cnt <= 6'(HOLD_DELAY_CYC + HOLD_WIDTH_CYC); // R22
      end else if (hold_cnt != 6'h0) begin
        hold_cnt <= hold_cnt - 6'h1;
      end
    end
  end

  // Trigger line drive: bit 0 front, bits 1..6 bus; star is never driven
  wire [6:0] map_start = line_map(outsel[OUT_START], outsel[OUT_START+1 +: 3]); // R3 R5
  wire [6:0] map_ref = line_map(outsel[OUT_REF], outsel[OUT_REF+1 +: 3]); // R9
  wire [6:0] map_scan = line_map(outsel[OUT_SCAN], outsel[OUT_SCAN+1 +: 3]) & 7'h7e; // R11
  wire [6:0] map_conv = line_map(outsel[OUT_CONV], outsel[OUT_CONV+1 +: 3]) & 7'h7e; // R16
  wire [6:0] next_line = (map_start & {7{start_on}}) | (map_ref & {7{ref_on}}) |
                         (map_scan & {7{scan_on}}) | (map_conv & {7{~conv_on}}); // R16
  wire [6:0] next_oe_n = ~(map_start | map_ref | map_scan | map_conv); // R18

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trig_front_out <= 1'b0;
      trig_front_oe_n <= 1'b1; // R5 R9
      trig_bus_out <= 6'h00;
      trig_bus_oe_n <= 6'h3f; // R11 R16
      adc_convert <= 1'b0;
      sample_held_pulse <= 1'b0;
      acq_running <= 1'b0;
    end else begin
      trig_front_out <= next_line[0];
      trig_front_oe_n <= next_oe_n[0];
      trig_bus_out <= next_line[6:1];
      trig_bus_oe_n <= next_oe_n[6:1];
      adc_convert <= conv_fire; // R15
      sample_held_pulse <= next_hold; // R22
      acq_running <= running;
    end
  end

  // Register file
  wire [31:0] status_word = {cq, 4'h0, running, scanning, state};
  wire [31:0] rd_word = (bus_adr == ACQTC_ADR_CTRL) ? ctrl :
                        (bus_adr == ACQTC_ADR_SRC) ? src :
                        (bus_adr == ACQTC_ADR_OUT) ? outsel :
                        (bus_adr == ACQTC_ADR_CONVS) ? convs :
                        (bus_adr == ACQTC_ADR_PRE) ? pre_cnt :
                        (bus_adr == ACQTC_ADR_POST) ? post_cnt :
                        (bus_adr == ACQTC_ADR_SCAN_IV) ? scan_iv :
                        (bus_adr == ACQTC_ADR_CONV_IV) ? conv_iv :
                        (bus_adr == ACQTC_ADR_STATUS) ? status_word : 32'h00000000;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RST;
      src <= SRC_RST;
      outsel <= OUT_RST;
      convs <= CONVS_RST;
      pre_cnt <= PRE_RST;
      post_cnt <= POST_RST;
      scan_iv <= SCAN_IV_RST;
      conv_iv <= CONV_IV_RST;
    end else begin
      if (wr_ctrl) ctrl <= merge_bytes(ctrl, wb_dat_i, wb_sel_i) & CTRL_MASK;
      if (wr_src) src <= merge_bytes(src, wb_dat_i, wb_sel_i) & SRC_MASK; // R1 R2
      if (wr_out) outsel <= merge_bytes(outsel, wb_dat_i, wb_sel_i) & OUT_MASK; // R3
      if (wr_convs) convs <= merge_bytes(convs, wb_dat_i, wb_sel_i) & CONVS_MASK; // R24
      if (wr_pre) pre_cnt <= merge_bytes(pre_cnt, wb_dat_i, wb_sel_i) & COUNT_MASK; // R24
      if (wr_post) post_cnt <= merge_bytes(post_cnt, wb_dat_i, wb_sel_i) & COUNT_MASK; // R24
      if (wr_scan_iv) scan_iv <= merge_bytes(scan_iv, wb_dat_i, wb_sel_i) & COUNT_MASK; // R24
      if (wr_conv_iv) conv_iv <= merge_bytes(conv_iv, wb_dat_i, wb_sel_i) & CONVS_MASK; // R24
    end
  end

endmodule : acqtc_top

// >>> verification/acqtc_far_end.sv
`timescale 1ns/1ps
module acqtc_far_end (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic fire,
  input wire logic [2:0] sel,
  input wire logic [7:0] idle,
  output logic [7:0] line
);
  logic [2:0] cnt;
  logic [2:0] hit;
  // Pulses last four cycles so each phase stays above 23 ns
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt <= 3'h0;
      hit <= 3'h0;
    end else if (fire) begin
      cnt <= 3'h4;
      hit <= sel;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  assign line = idle ^ ((cnt != 3'h0) ? (8'h01 << hit) : 8'h00);
endmodule : acqtc_far_end

// >>> verification/acqtc_top_monitor.sv
`timescale 1ns/1ps
module acqtc_top_monitor (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic trig_front_out,
  input wire logic trig_front_oe_n,
  input wire logic [5:0] trig_bus_oe_n,
  input wire logic adc_convert,
  input wire logic acq_running
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_hiz_at_start;
    $rose(rstn) |-> trig_front_oe_n && (trig_bus_oe_n == 6'h3f);
  endproperty
  a_hiz_at_start: assert property (p_hiz_at_start) else $error("line driven after reset");
  property p_conv_in_seq;
    adc_convert |-> acq_running || $past(acq_running);
  endproperty
  a_conv_in_seq: assert property (p_conv_in_seq) else $error("conversion outside run");
  property p_conv_after_stop;
    $fell(acq_running) |=> !adc_convert [*3];
  endproperty
  a_conv_after_stop: assert property (p_conv_after_stop) else $error("conversion after end");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_front_width;
    $rose(trig_front_out) |-> trig_front_out [*7] ##1 !trig_front_out;
  endproperty
  a_front_width: assert property (p_front_width) else $error("front pulse width");
  property p_front_oe_cause;
    $changed(trig_front_oe_n) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
  endproperty
  a_front_oe_cause: assert property (p_front_oe_cause) else $error("front enable moved");
  property p_bus_oe_cause;
    $changed(trig_bus_oe_n) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
  endproperty
  a_bus_oe_cause: assert property (p_bus_oe_cause) else $error("bus enable moved");
endmodule : acqtc_top_monitor
bind acqtc_top acqtc_top_monitor u_mon (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_front_out(trig_front_out),
  .trig_front_oe_n(trig_front_oe_n), .trig_bus_oe_n(trig_bus_oe_n), .adc_convert(adc_convert),
  .acq_running(acq_running));

// >>> verification/acqtc_top_test.sv
`timescale 1ns/1ps
module acqtc_top_test
  import acqtc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, trig_front_out, trig_front_oe_n, adc_convert, sample_held_pulse, acq_running;
  logic [5:0] trig_bus_out, trig_bus_oe_n, bus_w;
  logic fire = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] idle = 8'h00;
  logic [7:0] far_line;
  logic front_w, prev_f, prev_b1;
  int n_mismatch = 0;
  int checked = 0;
  int n_conv = 0;
  int n_front = 0;
  int n_low = 0;
  logic [7:0] adrs [10] = '{ACQTC_ADR_CTRL, ACQTC_ADR_SRC, ACQTC_ADR_OUT, ACQTC_ADR_CONVS,
    ACQTC_ADR_PRE, ACQTC_ADR_POST, ACQTC_ADR_SCAN_IV, ACQTC_ADR_CONV_IV, ACQTC_ADR_CMD, 8'h28};
  logic [31:0] rsts [10] = '{CTRL_RST, SRC_RST, OUT_RST, CONVS_RST, PRE_RST, POST_RST,
    SCAN_IV_RST, CONV_IV_RST, 32'h0, 32'h0};
  logic [31:0] msks [10] = '{CTRL_MASK, SRC_MASK, OUT_MASK, CONVS_MASK, COUNT_MASK, COUNT_MASK,
    COUNT_MASK, CONVS_MASK, 32'h0, 32'h0};
  // Wire levels: design wins where it drives, far end elsewhere
  assign front_w = trig_front_oe_n ? far_line[0] : trig_front_out;
  assign bus_w = (far_line[6:1] & trig_bus_oe_n) | (trig_bus_out & ~trig_bus_oe_n);
  acqtc_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_front_in(front_w), .trig_bus_in(bus_w),
    .trig_star_in(far_line[7]), .trig_front_out(trig_front_out),
    .trig_front_oe_n(trig_front_oe_n), .trig_bus_out(trig_bus_out),
    .trig_bus_oe_n(trig_bus_oe_n), .adc_convert(adc_convert),
    .sample_held_pulse(sample_held_pulse), .acq_running(acq_running));
  acqtc_far_end u_far (.clk_sys(clk_sys), .rstn(rstn), .fire(fire), .sel(sel), .idle(idle),
    .line(far_line));
  always #4 clk_sys = ~clk_sys;
  // Counts conversions, front pulses and low pulses on bus line 1
  always @(posedge clk_sys) begin
    if (adc_convert === 1'b1) n_conv++;
    if (trig_front_out === 1'b1 && !prev_f) n_front++;
    if (trig_bus_oe_n[1] === 1'b0 && prev_b1 && trig_bus_out[1] === 1'b0) n_low++;
    prev_f = (trig_front_out === 1'b1);
    prev_b1 = (trig_bus_out[1] !== 1'b0);
  end
  function automatic logic [31:0] n_expect(input logic [31:0] scans, input logic [31:0] per);
    return scans * ((per == 32'h0) ? 32'h1 : per);
  endfunction : n_expect
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wait_lvl(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (s !== v) begin
      n_mismatch++;
      close_out();
    end
  endtask : wait_lvl
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] be,
                    input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= be;
    wb_dat_i <= wd;
    wait_lvl(wb_ack_o, 1'b1, n);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, adr, 4'hf, d, r);
  endtask : wr
  task automatic fire_line(input logic [2:0] code);
    @(posedge clk_sys);
    fire <= 1'b1;
    sel <= code;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : fire_line
  initial begin
    logic [31:0] d, r;
    int cv, civ, c0, f0, l0, n, w;
    d = $urandom(19625);
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk("oe_n", {25'h0, trig_front_oe_n, trig_bus_oe_n}, 32'h7f);
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, adrs[i], 4'hf, 32'h0, r);
      chk("reset value", r, rsts[i]);
    end
    wb(1'b1, ACQTC_ADR_CONVS, 4'h2, 32'hffffab00, r);
    wb(1'b0, ACQTC_ADR_CONVS, 4'hf, 32'h0, r);
    chk("byte merge", r, 32'h0000ab01);
    for (int i = 0; i < 10; i++) begin
      d = $urandom();
      if (i == 0) d[CTRL_START_PIN] = 1'b0;
      if (i != 8) wr(adrs[i], d);
      wb(1'b0, adrs[i], 4'hf, 32'h0, r);
      chk("readback", r, d & msks[i]);
    end
    wr(ACQTC_ADR_CTRL, 32'h0);
    wr(ACQTC_ADR_SRC, 32'h0);
    cv = 1 + $urandom_range(3);
    civ = 7 + $urandom_range(3);
    wr(ACQTC_ADR_CONVS, 32'(cv));
    wr(ACQTC_ADR_CONV_IV, 32'(civ));
    wr(ACQTC_ADR_POST, 32'h2);
    wr(ACQTC_ADR_SCAN_IV, 32'h14);
    wr(ACQTC_ADR_OUT, 32'h5001);
    c0 = n_conv;
    f0 = n_front;
    l0 = n_low;
    wr(ACQTC_ADR_CMD, 32'h1);
    repeat (4) @(posedge clk_sys);
    chk("running", 32'(acq_running), 32'h1);
    wait_lvl(acq_running, 1'b0, n);
    repeat (4) @(posedge clk_sys);
    chk("conversions", 32'(n_conv - c0), n_expect(2, cv));
    chk("convert out", 32'(n_low - l0), n_expect(2, cv));
    chk("start out", 32'(n_front - f0), 32'h1);
    wr(ACQTC_ADR_OUT, 32'h10);
    wr(ACQTC_ADR_SRC, 32'h0200003d);
    wr(ACQTC_ADR_PRE, 32'h2);
    wr(ACQTC_ADR_POST, 32'h3);
    wr(ACQTC_ADR_CONVS, 32'h1);
    idle <= 8'h80;
    wr(ACQTC_ADR_CTRL, 32'h101);
    wr(ACQTC_ADR_CMD, 32'h1);
    repeat (10) @(posedge clk_sys);
    chk("pin start only", 32'(acq_running), 32'h0);
    fire_line(3'h5);
    chk("pin start", 32'(acq_running), 32'h1);
    fire_line(3'h7);
    wb(1'b0, ACQTC_ADR_STATUS, 4'hf, 32'h0, r);
    chk("early ref", {30'h0, r[1:0]}, 32'h1);
    repeat (400) @(posedge clk_sys);
    wb(1'b0, ACQTC_ADR_STATUS, 4'hf, 32'h0, r);
    chk("armed", {30'h0, r[1:0]}, 32'h2);
    f0 = n_front;
    fire_line(3'h7);
    wb(1'b0, ACQTC_ADR_STATUS, 4'hf, 32'h0, r);
    chk("post phase", {30'h0, r[1:0]}, 32'h3);
    wait_lvl(acq_running, 1'b0, n);
    chk("ref out", 32'(n_front - f0), 32'h1);
    wr(ACQTC_ADR_CTRL, 32'h40);
    wr(ACQTC_ADR_SRC, 32'h1000);
    idle <= 8'h02;
    c0 = n_conv;
    wr(ACQTC_ADR_CMD, 32'h1);
    repeat (500) @(posedge clk_sys);
    chk("paused", 32'(n_conv - c0), 32'h0);
    chk("paused run", 32'(acq_running), 32'h1);
    idle <= 8'h00;
    wait_lvl(adc_convert, 1'b1, n);
    wait_lvl(sample_held_pulse, 1'b1, n);
    wait_lvl(sample_held_pulse, 1'b0, w);
    chk("hold delay", 32'(n >= 7 && n <= 12), 32'h1);
    chk("hold width", 32'(w >= 50 && w <= 62), 32'h1);
    wait_lvl(acq_running, 1'b0, n);
    chk("scans after pause", 32'(n_conv - c0), 32'h3);
    wr(ACQTC_ADR_CTRL, 32'h2);
    wr(ACQTC_ADR_SRC, 32'h1c0);
    wr(ACQTC_ADR_CONVS, 32'h2);
    c0 = n_conv;
    fire_line(3'h7);
    chk("idle scan", 32'(n_conv - c0), 32'h0);
    wr(ACQTC_ADR_CMD, 32'h1);
    repeat (3) begin
      fire_line(3'h7);
      repeat (40) @(posedge clk_sys);
    end
    wait_lvl(acq_running, 1'b0, n);
    chk("external scans", 32'(n_conv - c0), n_expect(3, 2));
    wr(ACQTC_ADR_CTRL, 32'h0);
    wr(ACQTC_ADR_POST, 32'h64);
    wr(ACQTC_ADR_CMD, 32'h1);
    repeat (300) @(posedge clk_sys);
    wr(ACQTC_ADR_CMD, 32'h2);
    repeat (3) @(posedge clk_sys);
    chk("stopped", 32'(acq_running), 32'h0);
    c0 = n_conv;
    repeat (300) @(posedge clk_sys);
    chk("no convert", 32'(n_conv - c0), 32'h0);
    wr(ACQTC_ADR_CTRL, 32'h200);
    c0 = n_conv;
    wr(ACQTC_ADR_CMD, 32'h1);
    repeat (300) @(posedge clk_sys);
    chk("sw gate", 32'(n_conv - c0), 32'h0);
    chk("gated run", 32'(acq_running), 32'h1);
    wr(ACQTC_ADR_CMD, 32'h2);
    close_out();
  end
endmodule : acqtc_top_test
